// File: reader_status_pkg.sv
// package for the reader status reporter: register layouts, offsets,
// reset values, command codes and reply characters.
// assumes a single pclk domain and a 32-bit apb register bus.
package reader_status_pkg;

   // ************************************************************
   // register offsets (byte addresses)
   // ************************************************************
   localparam logic [7:0] off_cmd = 8'h00;
   localparam logic [7:0] off_append = 8'h04;
   localparam logic [7:0] off_proto = 8'h08;
   localparam logic [7:0] off_io = 8'h0c;
   localparam logic [7:0] off_rf = 8'h10;
   localparam logic [7:0] off_range = 8'h14;
   localparam logic [7:0] off_pres = 8'h18;
   localparam logic [7:0] off_filt = 8'h1c;
   localparam logic [7:0] off_status = 8'h20;

   // ************************************************************
   // register layouts
   // ************************************************************
   typedef struct packed {logic [21:0] rsvd; logic [9:0] code;} cmd_reg_type;
   typedef struct packed {logic [28:0] rsvd; logic aux; logic date; logic tm;} append_reg_type;
   typedef struct packed {logic [15:0] rsvd; logic [7:0] timeout; logic [3:0] rsvd1;
      logic [1:0] flow; logic [1:0] sel;} proto_reg_type;
   typedef struct packed {logic [22:0] rsvd; logic [3:0] pulse; logic owner;
      logic [1:0] outs; logic [1:0] ins;} io_reg_type;
   typedef struct packed {logic [19:0] rsvd; logic [6:0] freq; logic legacy;
      logic [1:0] uniq; logic rf_on; logic ctrl;} rf_reg_type;
   typedef struct packed {logic [3:0] rsvd; logic [3:0] atten_p; logic [3:0] rsvd1;
      logic [3:0] atten; logic [2:0] rsvd2; logic [4:0] range_b; logic [2:0] rsvd3;
      logic [4:0] range_a;} range_reg_type;
   typedef struct packed {logic [19:0] rsvd; logic invert; logic [3:0] rf_to;
      logic [1:0] rf_off; logic [3:0] min_pres; logic pres_rep;} pres_reg_type;
   typedef struct packed {logic [17:0] rsvd; logic [7:0] retx; logic card_en;
      logic [1:0] valid; logic [2:0] sep;} filt_reg_type;
   typedef struct packed {logic [23:0] rsvd; logic [5:0] count; logic err; logic busy;} status_reg_type;

   // ************************************************************
   // reset values and field limits
   // ************************************************************
   localparam append_reg_type append_reset = 32'h0000_0000;
   localparam proto_reg_type proto_reset = 32'h0000_0000;
   localparam io_reg_type io_reset = 32'h0000_0000;
   localparam rf_reg_type rf_reset = 32'h0000_0004;
   localparam range_reg_type range_reset = 32'h0000_0000;
   localparam pres_reg_type pres_reset = 32'h0000_0780;
   localparam filt_reg_type filt_reset = 32'h0000_0040;
   localparam logic [6:0] freq_max = 7'h76;
   localparam logic [3:0] atten_max = 4'ha;
   localparam logic [2:0] sep_max = 3'h4;
   localparam logic [3:0] pulse_unused = 4'he;

   // ************************************************************
   // command codes and reply characters
   // ************************************************************
   localparam logic [9:0] cmd_append = 10'h20c;
   localparam logic [9:0] cmd_proto = 10'h20d;
   localparam logic [9:0] cmd_io = 10'h20e;
   localparam logic [9:0] cmd_rf = 10'h20f;
   localparam logic [9:0] cmd_pres = 10'h211;
   localparam logic [9:0] cmd_filt = 10'h212;
   localparam logic [9:0] cmd_card = 10'h214;
   localparam logic [9:0] cmd_retx = 10'h215;
   localparam logic [5:0] msg_bytes = 6'h24;
   localparam logic [31:0] appended_info_reply_prefix = 32'h4944_4150;
   localparam logic [31:0] protocol_reply_prefix = 32'h4543_5053;
   localparam logic [31:0] io_reply_prefix = 32'h494f_5354;
   localparam logic [31:0] rf_reply_prefix = 32'h5246_5354;
   localparam logic [31:0] presence_reply_prefix = 32'h5052_5354;
   localparam logic [31:0] filter_reply_prefix = 32'h5246_3053;
   localparam logic [23:0] card_mode_reply_prefix = 24'h54_3046;
   localparam logic [23:0] card_retransmit_reply_prefix = 24'h57_5449;
   localparam logic [7:0] ch_sp = 8'h20;
   localparam logic [7:0] ch_cr = 8'h0d;
   localparam logic [7:0] ch_zero = 8'h30;
   localparam logic [15:0] fld_a = 16'h2041;
   localparam logic [15:0] fld_c = 16'h2043;
   localparam logic [15:0] fld_d = 16'h2044;
   localparam logic [15:0] fld_f = 16'h2046;
   localparam logic [15:0] fld_g = 16'h2047;
   localparam logic [15:0] fld_i = 16'h2049;
   localparam logic [15:0] fld_o = 16'h204f;
   localparam logic [15:0] fld_p = 16'h2050;
   localparam logic [15:0] fld_r = 16'h2052;
   localparam logic [15:0] fld_s = 16'h2053;
   localparam logic [15:0] fld_t = 16'h2054;
   localparam logic [15:0] fld_u = 16'h2055;
   localparam logic [15:0] fld_v = 16'h2056;
   localparam logic [15:0] fld_x = 16'h2058;

endpackage

// File: reader_status_reporter.sv
// reader status reporter: apb-programmed settings and a formatter that
// turns status commands into ascii reply lines streamed out byte by byte.
// assumes a serial transmitter downstream that takes one byte per
// tx_valid/tx_ready handshake, and raw discrete inputs on pins.
// Operation
// - append flags: time, date, aux, 0/1
// - protocol code 0 basic, 1 checked, 2 echo
// - timeout two hex digits, 50 ms units
// - flow control 0 none, 1 sw, 2 hw
// - start-of-message field always 0, hash sign
// - output owner 0 host, 1 predefined mode
// - outputs coded 0..3 by bit
// - inputs coded 0..3 by bit
// - pulse duration one hex digit code
// - rf control and rf on/off flags
// - uniqueness timeout codes 1, 2, 3
// - frequency three decimal digits 000..118
// - two decoder ranges, hex 00..1f
// - attenuations hex, 00..0a and 00..0f
// - legacy frequency entry shows two digits
// - presence report flag and min period code
// - rf-off condition codes 0, 1, 2
// - rf timeout one hex digit, f default
// - presence inversion flag, default off
// - id separation codes 0..4
// - valid-id criterion codes 0..3
// - card mode flag, retransmit interval 01..ff
`timescale 1ns/10ps
module reader_status_reporter
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // reply byte stream
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   // discrete i/o
   input wire logic [1:0] in_pin,
   output logic [1:0] out_pin,
   output logic rf_enable
);
   import reader_status_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   logic [9:0] code_q;
   append_reg_type append_q;
   proto_reg_type proto_q;
   io_reg_type io_q;
   rf_reg_type rf_q;
   range_reg_type range_q;
   pres_reg_type pres_q;
   filt_reg_type filt_q;
   logic err_q;
   logic busy_q;
   logic [5:0] cnt_q;
   logic [5:0] cnt_d;
   logic [287:0] msg_q;
   logic [287:0] msg_d;
   logic [287:0] msg_vec;
   logic [5:0] msg_len;
   logic [23:0] freq_txt;
   logic [1:0] in_s1_q;
   logic [1:0] in_s2_q;
   logic [1:0] in_s3_q;
   logic [1:0] ins_q;
   logic ready_q;
   logic err_resp_q;
   logic [31:0] rdata_q;

   // ************************************************************
   // apb decode
   // ************************************************************
   logic wr_en;
   logic setup;
   logic mapped;
   logic known_cmd;
   logic cmd_go;
   logic tx_take;
   proto_reg_type w_proto;
   io_reg_type w_io;
   rf_reg_type w_rf;
   range_reg_type w_range;
   pres_reg_type w_pres;
   filt_reg_type w_filt;

   assign setup = psel & ~penable;
   assign wr_en = psel & penable & ready_q & pwrite & ~err_resp_q;
   assign mapped = (paddr[7:2] <= off_status[7:2]);
   assign w_proto = pwdata;
   assign w_io = pwdata;
   assign w_rf = pwdata;
   assign w_range = pwdata;
   assign w_pres = pwdata;
   assign w_filt = pwdata;
   assign known_cmd = (pwdata[9:0] == cmd_append) | (pwdata[9:0] == cmd_proto) |
                      (pwdata[9:0] == cmd_io) | (pwdata[9:0] == cmd_rf) |
                      (pwdata[9:0] == cmd_pres) | (pwdata[9:0] == cmd_filt) |
                      (pwdata[9:0] == cmd_card) | (pwdata[9:0] == cmd_retx);
   // a command is only taken when no reply is still streaming out
   assign cmd_go = wr_en & (paddr[7:2] == off_cmd[7:2]) & known_cmd & ~busy_q;
   assign tx_take = busy_q & tx_ready;

   // registered apb answer: one access cycle, no extra wait states
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ready_q <= 1'b0;
         err_resp_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         ready_q <= setup;
         err_resp_q <= setup & ~mapped;
         if (setup & ~pwrite)
         begin
            case (paddr[7:2])
               off_cmd[7:2]: rdata_q <= {22'h000000, code_q};
               off_append[7:2]: rdata_q <= append_q;
               off_proto[7:2]: rdata_q <= proto_q;
               off_io[7:2]: rdata_q <= {io_q[31:2], ins_q};
               off_rf[7:2]: rdata_q <= rf_q;
               off_range[7:2]: rdata_q <= range_q;
               off_pres[7:2]: rdata_q <= pres_q;
               off_filt[7:2]: rdata_q <= filt_q;
               off_status[7:2]: rdata_q <= {24'h000000, cnt_q, err_q, busy_q};
               default: rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign prdata = rdata_q;
   assign pready = ready_q;
   assign pslverr = err_resp_q;

   // ************************************************************
   // settings registers
   // ************************************************************
   // out-of-range codes are clamped or dropped so every reply stays legal
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         append_q <= append_reset;
         proto_q <= proto_reset;
         io_q <= io_reset;
         rf_q <= rf_reset;
         range_q <= range_reset;
         pres_q <= pres_reset;
         filt_q <= filt_reset;
      end
      else if (wr_en)
      begin
         case (paddr[7:2])
            off_append[7:2]: append_q <= {29'h00000000, pwdata[2:0]};
            off_proto[7:2]:
            begin
               if (w_proto.sel != 2'h3)
                  proto_q.sel <= w_proto.sel;
               if (w_proto.flow != 2'h3)
                  proto_q.flow <= w_proto.flow;
               proto_q.timeout <= w_proto.timeout;
            end
            off_io[7:2]:
            begin
               io_q.owner <= w_io.owner;
               io_q.outs <= w_io.outs;
               if (w_io.pulse != pulse_unused)
                  io_q.pulse <= w_io.pulse;
            end
            off_rf[7:2]:
            begin
               rf_q.ctrl <= w_rf.ctrl;
               rf_q.rf_on <= w_rf.rf_on;
               rf_q.legacy <= w_rf.legacy;
               if (w_rf.uniq != 2'h0)
                  rf_q.uniq <= w_rf.uniq;
               rf_q.freq <= (w_rf.freq > freq_max) ? freq_max : w_rf.freq;
            end
            off_range[7:2]:
            begin
               range_q.range_a <= w_range.range_a;
               range_q.range_b <= w_range.range_b;
               range_q.atten <= (w_range.atten > atten_max) ? atten_max : w_range.atten;
               range_q.atten_p <= w_range.atten_p;
            end
            off_pres[7:2]:
            begin
               pres_q.pres_rep <= w_pres.pres_rep;
               pres_q.min_pres <= w_pres.min_pres;
               if (w_pres.rf_off != 2'h3)
                  pres_q.rf_off <= w_pres.rf_off;
               pres_q.rf_to <= w_pres.rf_to;
               pres_q.invert <= w_pres.invert;
            end
            off_filt[7:2]:
            begin
               filt_q.sep <= (w_filt.sep > sep_max) ? sep_max : w_filt.sep;
               filt_q.valid <= w_filt.valid;
               filt_q.card_en <= w_filt.card_en;
               filt_q.retx <= (w_filt.retx == 8'h00) ? 8'h01 : w_filt.retx;
            end
            default:
            begin
            end
         endcase
      end
   end

   assign out_pin = io_q.outs;
   assign rf_enable = rf_q.rf_on;

   // ************************************************************
   // discrete input synchroniser
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         in_s1_q <= 2'h0;
         in_s2_q <= 2'h0;
         in_s3_q <= 2'h0;
         ins_q <= 2'h0;
      end
      else
      begin
         in_s1_q <= in_pin;
         in_s2_q <= in_s1_q;
         in_s3_q <= in_s2_q;
         // a bit moves only once stages two and three agree
         ins_q <= (in_s2_q & in_s3_q) | (ins_q & (in_s2_q | in_s3_q));
      end
   end

   // ************************************************************
   // reply formatter
   // ************************************************************
   function automatic logic [7:0] hexc(input logic [3:0] n);
      hexc = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction

   function automatic logic [23:0] dec3(input logic [6:0] f);
      logic h;
      logic [6:0] r;
      logic [6:0] t;
      logic [6:0] u;
      h = (f >= 7'h64);
      r = h ? (f - 7'h64) : f;
      t = r / 7'h0a;
      u = r % 7'h0a;
      dec3 = {hexc({3'h0, h}), hexc(t[3:0]), hexc(u[3:0])};
   endfunction

   // decimal text of the channel, shared by both rf reply layouts
   assign freq_txt = dec3(rf_q.freq);

   always_comb
   begin
      msg_vec = 288'h0;
      msg_len = 6'h0;
      case (pwdata[9:0])
         cmd_append:
         begin
            msg_vec = 288'({appended_info_reply_prefix, fld_t, hexc({3'h0, append_q.tm}),
                            fld_d, hexc({3'h0, append_q.date}), fld_x, hexc({3'h0, append_q.aux}),
                            ch_cr});
            msg_len = 6'h0e;
         end
         cmd_proto:
         begin
            msg_vec = 288'({protocol_reply_prefix, fld_p, hexc({2'h0, proto_q.sel}),
                            fld_t, hexc(proto_q.timeout[7:4]), hexc(proto_q.timeout[3:0]),
                            fld_x, hexc({2'h0, proto_q.flow}),
                            fld_s, ch_zero, ch_cr});
            msg_len = 6'h12;
         end
         cmd_io:
         begin
            msg_vec = 288'({io_reply_prefix, fld_c, hexc({3'h0, io_q.owner}),
                            fld_o, hexc({2'h0, io_q.outs}),
                            fld_i, hexc({2'h0, ins_q}),
                            fld_d, hexc(io_q.pulse), ch_cr});
            msg_len = 6'h11;
         end
         cmd_rf:
         begin
            if (rf_q.legacy)
            begin
               msg_vec = 288'({rf_reply_prefix, fld_c, hexc({3'h0, rf_q.ctrl}),
                               fld_o, hexc({3'h0, rf_q.rf_on}), fld_t, hexc({2'h0, rf_q.uniq}),
                               fld_f, freq_txt[15:0],
                               fld_r, hexc({3'h0, range_q.range_a[4]}), hexc(range_q.range_a[3:0]),
                               fld_g, hexc({3'h0, range_q.range_b[4]}), hexc(range_q.range_b[3:0]),
                               fld_a, hexc(4'h0), hexc(range_q.atten),
                               fld_i, hexc(4'h0), hexc(range_q.atten_p), ch_cr});
               msg_len = 6'h22;
            end
            else
            begin
               msg_vec = 288'({rf_reply_prefix, fld_c, hexc({3'h0, rf_q.ctrl}),
                               fld_o, hexc({3'h0, rf_q.rf_on}), fld_t, hexc({2'h0, rf_q.uniq}),
                               fld_f, freq_txt,
                               fld_r, hexc({3'h0, range_q.range_a[4]}), hexc(range_q.range_a[3:0]),
                               fld_g, hexc({3'h0, range_q.range_b[4]}), hexc(range_q.range_b[3:0]),
                               fld_a, hexc(4'h0), hexc(range_q.atten),
                               fld_i, hexc(4'h0), hexc(range_q.atten_p), ch_cr});
               msg_len = 6'h23;
            end
         end
         cmd_pres:
         begin
            msg_vec = 288'({presence_reply_prefix, fld_p, hexc({3'h0, pres_q.pres_rep}),
                            fld_d, hexc(pres_q.min_pres),
                            fld_a, hexc({2'h0, pres_q.rf_off}),
                            fld_t, hexc(pres_q.rf_to),
                            fld_i, hexc({3'h0, pres_q.invert}), ch_cr});
            msg_len = 6'h14;
         end
         cmd_filt:
         begin
            msg_vec = 288'({filter_reply_prefix, fld_u, hexc({1'h0, filt_q.sep}),
                            fld_v, hexc({2'h0, filt_q.valid}), ch_cr});
            msg_len = 6'h0b;
         end
         cmd_card:
         begin
            msg_vec = 288'({card_mode_reply_prefix, ch_sp, hexc({3'h0, filt_q.card_en}), ch_cr});
            msg_len = 6'h06;
         end
         cmd_retx:
         begin
            msg_vec = 288'({card_retransmit_reply_prefix, ch_sp, hexc(filt_q.retx[7:4]),
                            hexc(filt_q.retx[3:0]), ch_cr});
            msg_len = 6'h07;
         end
         default:
         begin
            msg_vec = 288'h0;
            msg_len = 6'h0;
         end
      endcase
      // left-align so the first character sits in the top byte
      msg_d = msg_vec << {(msg_bytes - msg_len), 3'h0};
   end

   // ************************************************************
   // reply streaming
   // ************************************************************
   always_comb
   begin
      cnt_d = cnt_q;
      if (cmd_go)
         cnt_d = msg_len;
      else if (tx_take)
         cnt_d = cnt_q - 6'h01;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         msg_q <= 288'h0;
         cnt_q <= 6'h00;
         busy_q <= 1'b0;
         code_q <= 10'h000;
      end
      else
      begin
         cnt_q <= cnt_d;
         busy_q <= (cnt_d != 6'h00);
         if (cmd_go)
         begin
            msg_q <= msg_d;
            code_q <= pwdata[9:0];
         end
         else if (tx_take)
            msg_q <= {msg_q[279:0], 8'h00};
      end
   end

   assign tx_data = msg_q[287:280];
   assign tx_valid = busy_q;

   // refused command: unknown code or a reply still in flight; set beats clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         err_q <= 1'b0;
      else if (wr_en & (paddr[7:2] == off_cmd[7:2]) & (~known_cmd | busy_q))
         err_q <= 1'b1;
      else if (wr_en & (paddr[7:2] == off_status[7:2]) & pwdata[1])
         err_q <= 1'b0;
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence taken(logic [9:0] c);
      cmd_go && (pwdata[9:0] == c);
   endsequence

   append_reply_a: assert property (taken(cmd_append) |=> msg_q[287-8*6 -: 8] == hexc({3'h0, append_q.tm})
      && msg_q[287-8*13 -: 8] == ch_cr) else $error("append reply field wrong");
   proto_reply_a: assert property (taken(cmd_proto) |=> msg_q[287-8*6 -: 8] == hexc({2'h0, proto_q.sel})
      && msg_q[287-8*16 -: 8] == ch_zero) else $error("protocol reply field wrong");
   proto_timeout_a: assert property (taken(cmd_proto) |=> msg_q[287-8*9 -: 8] == hexc(proto_q.timeout[7:4])
      && msg_q[287-8*13 -: 8] == hexc({2'h0, proto_q.flow})) else $error("timeout or flow wrong");
   io_inputs_a: assert property (taken(cmd_io) |=> msg_q[287-8*12 -: 8] == hexc({2'h0, $past(ins_q)})
      && msg_q[287-8*15 -: 8] == hexc(io_q.pulse)) else $error("io reply field wrong");
   rf_freq_a: assert property (taken(cmd_rf) ##0 !rf_q.legacy |=> msg_q[287-8*14 -: 8] == 8'h46
      && cnt_q == 6'h23) else $error("rf frequency layout wrong");
   rf_legacy_a: assert property (taken(cmd_rf) ##0 rf_q.legacy |=> cnt_q == 6'h22)
      else $error("legacy frequency not shortened");
   pres_timeout_a: assert property (taken(cmd_pres) |=> msg_q[287-8*15 -: 8] == hexc(pres_q.rf_to))
      else $error("presence rf timeout wrong");
   filt_sep_a: assert property (filt_q.sep <= sep_max && filt_q.retx != 8'h00)
      else $error("filter field out of range");
   card_reply_a: assert property (taken(cmd_card) |=> tx_valid && tx_data == 8'h54 [*1] ##0
      msg_q[287-8*4 -: 8] == hexc({3'h0, filt_q.card_en})) else $error("card reply wrong");
   stream_step_a: assert property (tx_valid && tx_ready && cnt_q > 6'h01 |=> tx_valid && cnt_q == $past(cnt_q) - 6'h01)
      else $error("reply stream did not advance");
   busy_refuse_a: assert property (wr_en && paddr[7:2] == off_cmd[7:2] && busy_q |=> err_q && $stable(code_q))
      else $error("command taken while busy");
   in_sync_a: assert property ($rose(in_pin[0]) ##1 in_pin[0] [*3] |=> ins_q[0])
      else $error("input not taken after three stable cycles");

endmodule

// File: byte_sink.sv
// far-side consumer of the reply byte stream
// assumes the pclk domain and reset of the reporter
`timescale 1ns/10ps
module byte_sink
(
   // clock, reset and pacing
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   // reply stream
   output logic tx_ready
);
   // slow mode stalls every other cycle, so each byte must be held
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         tx_ready <= 1'b0;
      else
         tx_ready <= slow ? ~tx_ready : 1'b1;
endmodule

// File: reader_status_reporter_tb.sv
// self-checking bench for the reader status reporter
// assumes byte_sink as the far side of the reply stream
`timescale 1ns/10ps
module reader_status_reporter_tb;
   import reader_status_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, e;
   logic pready, pslverr, tx_valid, tx_ready, rf_enable;
   logic [7:0] paddr = 8'h00, tx_data;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [1:0] in_pin = 2'h1, out_pin;
   int errors = 0, n_checks = 0, cyc = 0;
   always #50 pclk = ~pclk;
   reader_status_reporter i_reader_status_reporter (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .in_pin(in_pin), .out_pin(out_pin), .rf_enable(rf_enable));
   byte_sink i_byte_sink (.pclk(pclk), .presetn(presetn), .slow(slow), .tx_ready(tx_ready));
   // a hang is cut short here; the run needs far fewer cycles
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         final_report;
      end
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk_s(input string got, input string exp);
      n_checks++;
      if (got != exp)
      begin
         errors++;
         $display("wrong value at %0t: reply '%s' not '%s'", $time, got, exp);
      end
   endtask
   task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // issue a command, gather bytes up to the carriage return, compare
   task automatic run(input logic [9:0] code, input string exp);
      string s = "";
      apb(1'b1, off_cmd, {22'h0, code});
      repeat (300)
      begin
         @(posedge pclk);
         if (tx_valid === 1'b1 && tx_ready === 1'b1 && tx_data === ch_cr)
            break;
         if (tx_valid === 1'b1 && tx_ready === 1'b1)
            s = {s, string'(tx_data)};
      end
      chk_s(s, exp);
   endtask
   task automatic t_defaults;
      apb(1'b0, off_rf, 32'h0);
      chk_v(rd, 32'h4);
      apb(1'b0, 8'h24, 32'h0);
      chk_v({rd[30:0], e}, 32'h1);
      run(cmd_pres, $sformatf("%s P0 D0 A0 TF I0", presence_reply_prefix));
      run(cmd_retx, $sformatf("%s 01", card_retransmit_reply_prefix));
      $display("test defaults done");
   endtask
   task automatic t_append_proto;
      apb(1'b1, off_append, 32'h3);
      run(cmd_append, $sformatf("%s T1 D1 X0", appended_info_reply_prefix));
      apb(1'b1, off_append, 32'h4);
      run(cmd_append, $sformatf("%s T0 D0 X1", appended_info_reply_prefix));
      apb(1'b1, off_proto, 32'hff06);
      run(cmd_proto, $sformatf("%s P2 TFF X1 S0", protocol_reply_prefix));
      apb(1'b1, off_proto, 32'h0a09);
      run(cmd_proto, $sformatf("%s P1 T0A X2 S0", protocol_reply_prefix));
      $display("test append and protocol done");
   endtask
   task automatic t_io;
      apb(1'b1, off_io, 32'h1f8);
      run(cmd_io, $sformatf("%s C1 O2 I1 DF", io_reply_prefix));
      chk_v({30'h0, out_pin}, 32'h2);
      apb(1'b1, off_io, 32'h0c);
      run(cmd_io, $sformatf("%s C0 O3 I1 D0", io_reply_prefix));
      in_pin <= 2'h2;
      repeat (5) @(posedge pclk);
      run(cmd_io, $sformatf("%s C0 O3 I2 D0", io_reply_prefix));
      in_pin <= 2'h3;
      repeat (5) @(posedge pclk);
      run(cmd_io, $sformatf("%s C0 O3 I3 D0", io_reply_prefix));
      $display("test io done");
   endtask
   task automatic t_rf;
      apb(1'b1, off_rf, 32'hecf);
      apb(1'b1, off_range, 32'h0f0a051f);
      run(cmd_rf, $sformatf("%s C1 O1 T3 F118 R1F G05 A0A I0F", rf_reply_prefix));
      chk_v({31'h0, rf_enable}, 32'h1);
      apb(1'b1, off_rf, 32'hedf);
      run(cmd_rf, $sformatf("%s C1 O1 T3 F18 R1F G05 A0A I0F", rf_reply_prefix));
      $display("test rf done");
   endtask
   task automatic t_pres_filt;
      apb(1'b1, off_pres, 32'hfc1);
      run(cmd_pres, $sformatf("%s P1 D0 A2 TF I1", presence_reply_prefix));
      apb(1'b1, off_filt, 32'h3ffc);
      slow <= 1'b1;
      run(cmd_filt, $sformatf("%s U4 V3", filter_reply_prefix));
      run(cmd_card, $sformatf("%s 1", card_mode_reply_prefix));
      run(cmd_retx, $sformatf("%s FF", card_retransmit_reply_prefix));
      slow <= 1'b0;
      $display("test presence and filter done");
   endtask
   // a command while a reply streams, and an unknown code, must both be refused
   task automatic t_refuse;
      apb(1'b1, off_cmd, {22'h0, cmd_card});
      apb(1'b1, off_cmd, {22'h0, cmd_retx});
      apb(1'b0, off_status, 32'h0);
      chk_v({31'h0, rd[1]}, 32'h1);
      apb(1'b0, off_cmd, 32'h0);
      chk_v(rd, {22'h0, cmd_card});
      apb(1'b1, off_status, 32'h2);
      apb(1'b0, off_status, 32'h0);
      chk_v(rd, 32'h0);
      apb(1'b1, off_cmd, 32'h210);
      apb(1'b0, off_status, 32'h0);
      chk_v(rd, 32'h2);
      $display("test refusal done");
   endtask
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_defaults;
      t_append_proto;
      t_io;
      t_rf;
      t_pres_filt;
      t_refuse;
      final_report;
   end
endmodule
